// file: verilog/szx_pkg.sv
package szx_pkg;
  localparam int unsigned SZX_WORD_W = 32;

  // Opcodes as decoded by the issue logic.
  localparam logic [7:0] SZX_OPC_WRITE_SPC  = 8'h9F;
  localparam logic [7:0] SZX_OPC_WRITE_PSW  = 8'hA1;
  localparam logic [7:0] SZX_OPC_ZEXT_HALF  = 8'h35;
  localparam logic [7:0] SZX_OPC_ZEXT_BYTE  = 8'h37;

  // Issue slot that hosts the flow-control unit.
  localparam logic [2:0] SZX_FC_SLOT        = 3'h3;

  localparam logic [31:0] SZX_PSW_RESET     = 32'h00000000;
  localparam logic [31:0] SZX_SPC_RESET     = 32'h00000000;
  localparam logic [31:0] SZX_DEST_RESET    = 32'h00000000;
  localparam logic [31:0] SZX_ZERO_REG      = 32'h00000000;

  localparam int unsigned SZX_HALF_W        = 16;
  localparam int unsigned SZX_BYTE_W        = 8;
endpackage

// file: verilog/szx_exec.sv
`timescale 1ns/10ps
// Notes on behaviour
// - A status word write changes only the bits whose mask bit is 1.
// - Bits that hardware updates in the same cycle take the hardware value.
// - Every operation updates its target only when the guard is absent or its LSB is 1.
// - The status word holds control and event fields, cleared or restored by masked writes.
// - Opcode 159 in slot 3 copies its operand into the source program counter.
// - A software write of the source program counter beats a same-cycle jump update.
// - An uninterrupted interruptible jump loads its target into the source program counter.
// - Opcode 53 writes the low 16 source bits zero-extended to 32 bits.
// - Halfword zero-extend equals pack-low-halves with a zero first operand.
// - Opcode 55 writes the low source byte with the upper 24 bits cleared.
// - Byte zero-extend is the unsigned byte select of byte 0 with the zero register supplying the byte index.
module szx_exec
  import szx_pkg::*;
(
  // Clock and reset.
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_n_in,
  // Issue port.
  input  wire logic                  issue_valid_in,
  input  wire logic [7:0]            opcode_in,
  input  wire logic [2:0]            issue_slot_in,
  input  wire logic                  guard_present_in,
  input  wire logic [SZX_WORD_W-1:0] guard_value_in,
  input  wire logic [SZX_WORD_W-1:0] src1_in,
  input  wire logic [SZX_WORD_W-1:0] src2_in,
  // Hardware status word update.
  input  wire logic [SZX_WORD_W-1:0] hw_psw_mask_in,
  input  wire logic [SZX_WORD_W-1:0] hw_psw_value_in,
  // Interruptible jump.
  input  wire logic                  ijump_valid_in,
  input  wire logic [SZX_WORD_W-1:0] ijump_target_in,
  input  wire logic                  nmi_pending_in,
  input  wire logic                  int_pending_in,
  input  wire logic                  exception_event_in,
  // Results.
  output logic [SZX_WORD_W-1:0]      program_status_word_out,
  output logic [SZX_WORD_W-1:0]      source_program_counter_out,
  output logic [SZX_WORD_W-1:0]      dest_data_out,
  output logic                       dest_valid_out
);
  import szx_pkg::*;

  logic [SZX_WORD_W-1:0] psw_r;
  logic [SZX_WORD_W-1:0] psw_nxt;
  logic [SZX_WORD_W-1:0] spc_r;
  logic [SZX_WORD_W-1:0] spc_nxt;
  logic [SZX_WORD_W-1:0] dest_r;
  logic [SZX_WORD_W-1:0] dest_nxt;
  logic                  dest_vld_r;
  logic                  guard_ok;
  logic                  do_psw;
  logic                  do_spc;
  logic                  do_zh;
  logic                  do_zb;
  logic                  jump_clean;
  logic [SZX_WORD_W-1:0] pack_lo;
  logic [SZX_WORD_W-1:0] byte_sel;

  // An absent guard acts as a true one.
  assign guard_ok = !guard_present_in || guard_value_in[0];

  // Status word and program counter writes only exist on the flow-control slot.
  assign do_psw = issue_valid_in && guard_ok && (opcode_in == SZX_OPC_WRITE_PSW)
                  && (issue_slot_in == SZX_FC_SLOT);
  assign do_spc = issue_valid_in && guard_ok && (opcode_in == SZX_OPC_WRITE_SPC)
                  && (issue_slot_in == SZX_FC_SLOT);
  assign do_zh  = issue_valid_in && guard_ok && (opcode_in == SZX_OPC_ZEXT_HALF);
  assign do_zb  = issue_valid_in && guard_ok && (opcode_in == SZX_OPC_ZEXT_BYTE);

  assign jump_clean = ijump_valid_in && !nmi_pending_in && !int_pending_in
                      && !exception_event_in;

  // Pack-low-halves with the zero register in the upper half.
  assign pack_lo  = {SZX_ZERO_REG[SZX_HALF_W-1:0], src1_in[SZX_HALF_W-1:0]};
  // Unsigned select of byte 0; the zero register supplies the byte index.
  assign byte_sel = {24'h000000, src1_in[SZX_BYTE_W*SZX_ZERO_REG[1:0] +: SZX_BYTE_W]};

  // Event fields are cleared or restored by the same masked merge, one bit at a time.
  // Hardware updates win per bit, so a trap raised in the same cycle is never lost.
  for (genvar b = 0; b < SZX_WORD_W; b++) begin : g_psw_bit
    assign psw_nxt[b] = hw_psw_mask_in[b]      ? hw_psw_value_in[b] :
                        (do_psw && src2_in[b]) ? src1_in[b]         :
                                                 psw_r[b];

    a_psw_bit_keep: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      (!hw_psw_mask_in[b] && !(do_psw && src2_in[b]))
        |=> psw_r[b] == $past(psw_r[b]))
      else $error("Status bit changed without mask or hardware update.");
  end

  always_comb begin
    spc_nxt = spc_r;
    if (do_spc) begin
      spc_nxt = src1_in;
    end else if (jump_clean) begin
      spc_nxt = ijump_target_in;
    end
  end

  always_comb begin
    dest_nxt = dest_r;
    if (do_zh) begin
      dest_nxt = pack_lo;
    end else if (do_zb) begin
      dest_nxt = byte_sel;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      psw_r <= SZX_PSW_RESET;
    end else begin
      psw_r <= psw_nxt;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      spc_r <= SZX_SPC_RESET;
    end else begin
      spc_r <= spc_nxt;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dest_r     <= SZX_DEST_RESET;
      dest_vld_r <= 1'b0;
    end else begin
      dest_r     <= dest_nxt;
      dest_vld_r <= do_zh || do_zb;
    end
  end

  assign program_status_word_out    = psw_r;
  assign source_program_counter_out = spc_r;
  assign dest_data_out              = dest_r;
  assign dest_valid_out             = dest_vld_r;

  sequence s_psw_wr;
    do_psw && (hw_psw_mask_in == 32'h00000000);
  endsequence

  a_psw_masked_write: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    s_psw_wr |=> psw_r == (($past(psw_r) & ~$past(src2_in)) | ($past(src1_in) & $past(src2_in))))
    else $error("Status word masked write wrong.");

  a_psw_hw_wins: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    1'b1 |=> ((psw_r & $past(hw_psw_mask_in)) == ($past(hw_psw_value_in) & $past(hw_psw_mask_in))))
    else $error("Hardware status bits not applied.");

  a_psw_guard_off: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (!guard_ok && hw_psw_mask_in == 32'h00000000) |=> $stable(psw_r))
    else $error("Status word changed with false guard.");

  a_spc_sw_write: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    do_spc |=> spc_r == $past(src1_in))
    else $error("Program counter write lost.");

  a_spc_sw_wins: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (do_spc && jump_clean) |=> spc_r == $past(src1_in))
    else $error("Jump overrode software write.");

  a_spc_jump_load: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (!do_spc && ijump_valid_in && !nmi_pending_in && !int_pending_in && !exception_event_in)
      |=> spc_r == $past(ijump_target_in))
    else $error("Clean jump did not load counter.");

  a_spc_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (!do_spc && !jump_clean) |=> $stable(spc_r))
    else $error("Program counter changed unexpectedly.");

  a_zext_half: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    do_zh |=> dest_valid_out && dest_data_out == {16'h0000, $past(src1_in[15:0])})
    else $error("Halfword zero-extend wrong.");

  a_zext_byte: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    do_zb |=> dest_valid_out && dest_data_out == {24'h000000, $past(src1_in[7:0])})
    else $error("Byte zero-extend wrong.");

  a_dest_guard: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !(do_zh || do_zb) |=> !dest_valid_out && $stable(dest_data_out))
    else $error("Destination changed without operation.");

  // Refused and blocked requests must leave every architectural register alone.
  sequence s_psw_refused;
    issue_valid_in && (opcode_in == SZX_OPC_WRITE_PSW) && (issue_slot_in != SZX_FC_SLOT)
      && (hw_psw_mask_in == 32'h00000000);
  endsequence

  sequence s_spc_refused;
    issue_valid_in && (opcode_in == SZX_OPC_WRITE_SPC) && (issue_slot_in != SZX_FC_SLOT)
      && !jump_clean;
  endsequence

  sequence s_jump_blocked;
    ijump_valid_in && !do_spc && (nmi_pending_in || int_pending_in || exception_event_in);
  endsequence

  sequence s_extend;
    do_zh || do_zb;
  endsequence

  sequence s_spc_wr;
    do_spc;
  endsequence

  sequence s_jump_only;
    jump_clean && !do_spc;
  endsequence

  a_psw_slot_only: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    s_psw_refused |=> $stable(psw_r))
    else $error("Status word written outside its slot.");

  a_psw_guard_refused: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (issue_valid_in && (opcode_in == SZX_OPC_WRITE_PSW) && !guard_ok
      && (hw_psw_mask_in == 32'h00000000)) |=> $stable(psw_r))
    else $error("Status word written with false guard.");

  a_psw_restore: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (do_psw && (src2_in == 32'hFFFFFFFF) && (hw_psw_mask_in == 32'h00000000))
      |=> psw_r == $past(src1_in))
    else $error("Full status word restore wrong.");

  a_psw_event_clear: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (do_psw && (hw_psw_mask_in == 32'h00000000))
      |=> (psw_r & $past(src2_in)) == ($past(src1_in) & $past(src2_in)))
    else $error("Masked status bits not taken from operand.");

  a_psw_hw_only: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !do_psw |=> psw_r == (($past(psw_r) & ~$past(hw_psw_mask_in))
      | ($past(hw_psw_value_in) & $past(hw_psw_mask_in))))
    else $error("Hardware-only status update wrong.");

  a_psw_sw_beside_hw: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    do_psw |=> (psw_r & ~$past(hw_psw_mask_in)) == ((($past(psw_r) & ~$past(src2_in))
      | ($past(src1_in) & $past(src2_in))) & ~$past(hw_psw_mask_in)))
    else $error("Software bits lost beside hardware update.");

  a_spc_slot_only: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    s_spc_refused |=> $stable(spc_r))
    else $error("Program counter written outside its slot.");

  a_spc_guard_off: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (issue_valid_in && (opcode_in == SZX_OPC_WRITE_SPC) && !guard_ok && !jump_clean)
      |=> $stable(spc_r))
    else $error("Program counter written with false guard.");

  a_spc_event_block: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    s_jump_blocked |=> $stable(spc_r))
    else $error("Interrupted jump loaded the counter.");

  a_spc_back_to_back: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    s_spc_wr ##1 s_spc_wr |=> spc_r == $past(src1_in))
    else $error("Second counter write lost.");

  a_jump_back_to_back: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    s_jump_only ##1 s_jump_only |=> spc_r == $past(ijump_target_in))
    else $error("Second jump target lost.");

  a_spc_out_write: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    s_spc_wr |=> source_program_counter_out == $past(src1_in))
    else $error("Counter write not visible next cycle.");

  a_spc_out_jump: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    s_jump_only |=> source_program_counter_out == $past(ijump_target_in))
    else $error("Jump target not visible next cycle.");

  a_psw_out_follows: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    1'b1 |=> program_status_word_out == $past(psw_nxt))
    else $error("Status word not visible next cycle.");

  a_zh_low_half: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    do_zh |=> dest_data_out[15:0] == $past(src1_in[15:0]))
    else $error("Halfword extend low half wrong.");

  a_zh_upper_zero: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    do_zh |=> dest_data_out[31:16] == 16'h0000)
    else $error("Halfword extend upper half not zero.");

  a_zb_low_byte: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    do_zb |=> dest_data_out[7:0] == $past(src1_in[7:0]))
    else $error("Byte extend low byte wrong.");

  a_zb_upper_zero: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    do_zb |=> dest_data_out[31:8] == 24'h000000)
    else $error("Byte extend upper bits not zero.");

  a_zext_guard_off: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    (issue_valid_in && !guard_ok) |=> !dest_valid_out)
    else $error("Result flagged with false guard.");

  a_dest_valid_follow: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    s_extend |=> dest_valid_out)
    else $error("Result not flagged next cycle.");

  a_dest_pulse: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    s_extend ##1 !(do_zh || do_zb) |=> !dest_valid_out)
    else $error("Result flag stood too long.");

  a_dest_hold: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    s_extend ##1 !(do_zh || do_zb) |=> $stable(dest_data_out))
    else $error("Result did not hold after extend.");
endmodule

// file: testbench/test_status_pc_write_zero_extend.sv
`timescale 1ns/10ps
module test_status_pc_write_zero_extend;
  import szx_pkg::*;
  logic        clk = 0, rst_n = 0, iv = 0, gp = 0, jv = 0, nmi = 0, ip = 0, exception_event = 0, dv;
  logic [7:0]  opc = 8'h00;
  logic [2:0]  slot = 3'h0;
  logic [31:0] gv = '0, s1 = '0, s2 = '0, hm = '0, hv = '0, jt = '0, psw, source_program_counter, dd;
  int          err_total = 0;
  int          compares = 0;

  szx_exec dut (.sys_clk_in(clk), .reset_n_in(rst_n), .issue_valid_in(iv), .opcode_in(opc),
    .issue_slot_in(slot), .guard_present_in(gp), .guard_value_in(gv), .src1_in(s1),
    .src2_in(s2), .hw_psw_mask_in(hm), .hw_psw_value_in(hv), .ijump_valid_in(jv),
    .ijump_target_in(jt), .nmi_pending_in(nmi), .int_pending_in(ip),
    .exception_event_in(exception_event), .program_status_word_out(psw),
    .source_program_counter_out(source_program_counter), .dest_data_out(dd), .dest_valid_out(dv));

  initial begin
    forever #10 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Drives one issue and returns at the next falling edge, with its result visible.
  task op(input logic [7:0] o, input logic [2:0] sl, input logic p, input logic [31:0] g,
          input logic [31:0] a, input logic [31:0] b);
    iv = 1; opc = o; slot = sl; gp = p; gv = g; s1 = a; s2 = b;
    @(negedge clk);
  endtask

  task idle;
    iv = 0; hm = '0; jv = 0;
    @(negedge clk);
  endtask

  task t_psw;
    chk(psw, SZX_PSW_RESET); chk(source_program_counter, SZX_SPC_RESET); chk(dd, SZX_DEST_RESET);
    op(8'hA1, 3'h3, 0, 0, 32'h00000100, 32'h00000180); chk(psw, 32'h00000100);
    op(8'hA1, 3'h3, 0, 0, 32'h80110000, 32'hFFFF0000); chk(psw, 32'h80110100);
    op(8'hA1, 3'h3, 1, 32'hFFFFFFFE, 0, 32'hFFFFFFFF); chk(psw, 32'h80110100);
    op(8'hA1, 3'h2, 0, 0, 32'hFFFFFFFF, 32'hFFFFFFFF); chk(psw, 32'h80110100);
    op(8'hA1, 3'h3, 1, 1, 0, 32'h80000000); chk(psw, 32'h00110100);
    hm = 32'h0000000F; hv = 32'h00000005;
    op(8'hA1, 3'h3, 0, 0, 32'h000000FA, 32'h000000FF); chk(psw, 32'h001101F5);
    idle;
    $display("test psw done");
  endtask

  task t_spc;
    int i;
    op(8'h9F, 3'h3, 0, 0, 32'h00BEEBEE, 0); chk(source_program_counter, 32'h00BEEBEE);
    op(8'h9F, 3'h3, 1, 0, 32'h0000ABBA, 0); chk(source_program_counter, 32'h00BEEBEE);
    op(8'h9F, 3'h1, 0, 0, 32'h0000ABBA, 0); chk(source_program_counter, 32'h00BEEBEE);
    iv = 0; jv = 1;
    // Any pending event must stop the jump from loading its target.
    for (i = 0; i < 3; i++) begin
      nmi = (i == 0); ip = (i == 1); exception_event = (i == 2); jt = 32'hDEAD0000 + i;
      @(negedge clk); chk(source_program_counter, 32'h00BEEBEE);
    end
    nmi = 0; ip = 0; exception_event = 0; jt = 32'h00004000;
    @(negedge clk); chk(source_program_counter, 32'h00004000);
    jt = 32'h00005000;
    op(8'h9F, 3'h3, 0, 0, 32'h0000ABBA, 0); chk(source_program_counter, 32'h0000ABBA);
    idle;
    $display("test spc done");
  endtask

  task t_zext;
    op(8'h35, 3'h1, 0, 0, 32'hFFFF0040, 0); chk(dd, 32'h00000040); chk({31'h0, dv}, 1);
    op(8'h37, 3'h4, 1, 1, 32'hFF0FFF91, 0); chk(dd, 32'h00000091); chk({31'h0, dv}, 1);
    op(8'h35, 3'h5, 1, 32'h2, 32'hFF0FFF91, 0); chk(dd, 32'h00000091);
    chk({31'h0, dv}, 0);
    op(8'h35, 3'h2, 0, 0, 32'hFF0FFF91, 0); chk(dd, 32'h0000FF91);
    op(8'h37, 3'h3, 0, 0, 32'h12345680, 0); chk(dd, 32'h00000080);
    idle; chk({31'h0, dv}, 0);
    $display("test zext done");
  endtask

  task final_report;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1;
    t_psw;
    t_spc;
    t_zext;
    final_report;
  end
endmodule
